//--- src/scr_pkg.sv
// Constants, types and register map of the sync clock reference block
// Contract
// - Two-phase lead order gives transport direction
// - Direction used only for pulse position source
// - Clock derived from pulses while the implied rate stays within the clamp
// - Tach: one line direction, other rate pulses
// - Pulses per frame accepts 2 through 254
// - Internal reference drives all digital clocks
// - Generator timing follows the word clock of the selected reference
// - Rate trim limited to plus/minus 699 cents
// - Rate trim works for every position source
// - Output rate clamped 35-50 kHz, flagged
// - Rate hold keeps last rate on loss
// - Without hold, loss returns nominal rate
// - Rate hold setting survives power cycles
// - Position source selects reading or generating
// - Generating drives LTC, VITC, MTC together
// - Panel press advances reference cyclically
// - Lock indicator blinks on loss or bad setup
package scr_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int ACC_W = 32;
  localparam int TRIM_W = 11;
  localparam int PPF_W = 8;
  localparam int POS_W = 24;
  localparam int MEAS_W = 20;
  localparam int SPF_W = 11;
  localparam longint CLK_HZ = 125000000;
  localparam longint FS_NOM_HZ = 44100;
  localparam longint FS_MIN_HZ = 35000;
  localparam longint FS_MAX_HZ = 50000;
  localparam longint OVS = 512;
  localparam longint FPS = 30;
  // Phase increments of the 512x rate accumulator
  localparam longint INC_NOM = FS_NOM_HZ * OVS * (64'h1 << ACC_W) / CLK_HZ;
  localparam longint INC_MIN = FS_MIN_HZ * OVS * (64'h1 << ACC_W) / CLK_HZ;
  localparam longint INC_MAX = FS_MAX_HZ * OVS * (64'h1 << ACC_W) / CLK_HZ;
  localparam int TRIM_MAX = 699;
  // Linear cents law: ratio about 1 + c/1731
  localparam longint CENT_K = 1211;
  localparam int CENT_SHIFT = 21;
  localparam int PPF_MIN = 2;
  localparam int PPF_MAX = 254;
  localparam logic [PPF_W-1:0] PPF_RST = 8'h04;
  localparam logic [SPF_W-1:0] SPF_LAST = SPF_W'(FS_NOM_HZ / FPS - 1);
  localparam logic [MEAS_W-1:0] FRAME_OVF = MEAS_W'(FS_NOM_HZ / FPS * OVS);
  localparam logic [MEAS_W-1:0] WORD_OVF = MEAS_W'(OVS);
  localparam logic [ACC_W-1:0] FLL_STEP = 32'h0000_0100;
  localparam logic [1:0] NV_DONE = 2'h3;
  localparam longint LOSS_MS = 100;
  localparam longint BLINK_MS = 250;
  localparam int unsigned LOSS_CYC = 32'(LOSS_MS * CLK_HZ / 1000);
  localparam int unsigned BLINK_CYC = 32'(BLINK_MS * CLK_HZ / 1000);
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TRIM = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PPF = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_POS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RATE = 8'h14;
  localparam int CTRL_REF_LSB = 0;
  localparam int CTRL_POS_LSB = 2;
  localparam int CTRL_HOLD_BIT = 4;
  localparam int STAT_CLAMP = 1;
  typedef enum logic [1:0] {REF_INTERNAL, REF_TWO_PHASE, REF_TACH, REF_DIGITAL} scr_clk_ref_e;
  typedef enum logic [1:0] {POS_GENERATE, POS_LTC, POS_VITC, POS_PULSE} scr_pos_src_e;
endpackage

//--- src/scr_pulse_decoder.sv
// Two-phase and tach pulse decoder with frame position counter
`timescale 1ns/1ps
module scr_pulse_decoder (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Transport pins
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  // Control
  input wire logic tach_mode,
  input wire logic dir_used,
  input wire logic [scr_pkg::PPF_W-1:0] pulses_per_frame_setting,
  // Results
  output logic rate_pulse,
  output logic frame_tick,
  output logic direction,
  output logic [scr_pkg::POS_W-1:0] frame_pos
);
  import scr_pkg::*;

  logic [1:0] s1_reg, s2_reg, s3_reg;
  logic [PPF_W-1:0] cnt_reg;
  wire a_now = s2_reg[0];
  wire b_now = s2_reg[1];
  wire a_edge = a_now ^ s3_reg[0];
  wire a_rise = a_now & ~s3_reg[0];
  wire dir_now = tach_mode ? b_now : (a_edge ? (a_now ^ b_now) : direction);
  wire fwd = dir_used ? dir_now : 1'h1;
  wire [PPF_W-1:0] ppf_last = PPF_W'(pulses_per_frame_setting - 8'h01);
  wire wrap_up = fwd && cnt_reg >= ppf_last;
  wire wrap_dn = !fwd && cnt_reg == '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      direction <= 1'h1;
    end else begin
      s1_reg <= {phase_b_pin, phase_a_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      direction <= dir_now;
    end
  end

  // Rate pulse on each A rise serves both modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      frame_pos <= '0;
      rate_pulse <= 1'h0;
      frame_tick <= 1'h0;
    end else begin
      rate_pulse <= a_rise;
      frame_tick <= a_rise && (wrap_up || wrap_dn);
      if (a_rise) begin
        if (wrap_up) begin
          cnt_reg <= '0;
          frame_pos <= frame_pos + 24'h1;
        end else if (wrap_dn) begin
          cnt_reg <= ppf_last;
          frame_pos <= frame_pos - 24'h1;
        end else if (fwd) begin
          cnt_reg <= cnt_reg + 8'h01;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_tach_dir;
    tach_mode |=> direction == $past(b_now);
  endproperty
  a_tach_dir: assert property (p_tach_dir) else $error("tach direction not the level line");

  property p_fwd_only;
    !dir_used && a_rise && cnt_reg < ppf_last |=> cnt_reg == $past(cnt_reg) + 8'h01;
  endproperty
  a_fwd_only: assert property (p_fwd_only) else $error("direction used while ignored");
endmodule

//--- src/scr_top.sv
// Clock reference select, rate engine and register slave
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module scr_top #(
  parameter int unsigned LOSS_CYC_P = scr_pkg::LOSS_CYC,
  parameter int unsigned BLINK_CYC_P = scr_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [scr_pkg::DATA_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [scr_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [scr_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Transport, reference and panel pins
  input wire logic phase_a_pin,
  input wire logic phase_b_pin,
  input wire logic ext_ref_pin,
  input wire logic panel_sel_pin,
  input wire logic hold_nv_pin,
  // Digital clock outputs
  output logic word_clk,
  output logic wide_clk,
  output logic aes_clk,
  // Generator and indicators
  output logic gen_enable,
  output logic gen_frame_tick,
  output logic lock_led,
  output logic rate_clamped,
  output logic hold_nv_value
);
  import scr_pkg::*;

  localparam int LW = $clog2(LOSS_CYC_P + 1);
  localparam int BW = $clog2(BLINK_CYC_P + 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= {hold_nv_pin, panel_sel_pin, ext_ref_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  wire ext_edge = pin_s2_reg[0] & ~pin_s3_reg[0];
  wire panel_edge = pin_s2_reg[1] & ~pin_s3_reg[1];
  wire hold_nv_lvl = pin_s2_reg[2];

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Reads take one wait state so a write just before is seen
  logic dp_wr_reg, rd_pend_reg, hreadyout_reg;
  logic [ADDR_W-1:0] dp_addr_reg;
  logic [DATA_W-1:0] hrdata_reg;
  logic [DATA_W-1:0] rd_mux;
  wire take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
  wire wr_ctrl = dp_wr_reg && dp_addr_reg == REG_CTRL;
  wire wr_trim = dp_wr_reg && dp_addr_reg == REG_TRIM;
  wire wr_ppf = dp_wr_reg && dp_addr_reg == REG_PPF;
  wire wr_stat = dp_wr_reg && dp_addr_reg == REG_STAT;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'h0;
      rd_pend_reg <= 1'h0;
      hreadyout_reg <= 1'h1;
      dp_addr_reg <= '0;
      hrdata_reg <= '0;
    end else begin
      dp_wr_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      hreadyout_reg <= !(take && !hwrite);
      if (take) dp_addr_reg <= haddr[ADDR_W-1:0];
      if (rd_pend_reg) hrdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  scr_clk_ref_e clk_ref_reg;
  scr_pos_src_e pos_src_reg;
  logic rate_hold_reg, clamp_stk_reg, clamp_live_reg;
  logic [1:0] nv_cnt_reg;
  logic signed [TRIM_W-1:0] trim_reg;
  logic [PPF_W-1:0] ppf_reg;
  wire signed [DATA_W-1:0] wd_s = $signed(hwdata);
  wire signed [TRIM_W-1:0] trim_sat = wd_s > TRIM_MAX ? TRIM_W'(TRIM_MAX) :
    wd_s < -TRIM_MAX ? TRIM_W'(-TRIM_MAX) : wd_s[TRIM_W-1:0];
  wire ppf_ok = hwdata >= PPF_MIN && hwdata <= PPF_MAX;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_ref_reg <= REF_INTERNAL;
      pos_src_reg <= POS_GENERATE;
      rate_hold_reg <= 1'h0;
      nv_cnt_reg <= '0;
    end else begin
      if (nv_cnt_reg != NV_DONE) nv_cnt_reg <= nv_cnt_reg + 2'h1;
      if (wr_ctrl) begin
        clk_ref_reg <= scr_clk_ref_e'(hwdata[CTRL_REF_LSB +: 2]);
        pos_src_reg <= scr_pos_src_e'(hwdata[CTRL_POS_LSB +: 2]);
        rate_hold_reg <= hwdata[CTRL_HOLD_BIT];
      end else begin
        if (panel_edge) clk_ref_reg <= scr_clk_ref_e'(clk_ref_reg + 2'h1);
        if (nv_cnt_reg == NV_DONE - 2'h1) rate_hold_reg <= hold_nv_lvl;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_reg <= '0;
      ppf_reg <= PPF_RST;
      clamp_stk_reg <= 1'h0;
    end else begin
      if (wr_trim) trim_reg <= trim_sat;
      if (wr_ppf && ppf_ok) ppf_reg <= hwdata[PPF_W-1:0];
      clamp_stk_reg <= clamp_live_reg | (clamp_stk_reg & ~(wr_stat & hwdata[STAT_CLAMP]));
    end
  end

  // ----------------------------------------
  // Pulse decoder
  // ----------------------------------------
  logic rate_pulse, frame_tick, direction;
  logic [POS_W-1:0] frame_pos;
  scr_pulse_decoder u_dec (
    .hclk(hclk),
    .hresetn(hresetn),
    .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin),
    .tach_mode(clk_ref_reg == REF_TACH),
    .dir_used(pos_src_reg == POS_PULSE),
    .pulses_per_frame_setting(ppf_reg),
    .rate_pulse(rate_pulse),
    .frame_tick(frame_tick),
    .direction(direction),
    .frame_pos(frame_pos)
  );

  // ----------------------------------------
  // Reference tracking
  // ----------------------------------------
  // Pulse references are compared once per frame, so a slow
  // transport still steers the rate without a divider on ppf
  logic [ACC_W-1:0] base_inc_reg, base_inc_next;
  logic [MEAS_W-1:0] meas_cnt_reg;
  logic [LW-1:0] loss_cnt_reg;
  logic out_lock_reg, ovf_reg;
  wire internal = clk_ref_reg == REF_INTERNAL;
  wire pulse_ref = clk_ref_reg == REF_TWO_PHASE || clk_ref_reg == REF_TACH;
  wire fll_evt = pulse_ref ? frame_tick : ext_edge;
  wire act_evt = pulse_ref ? rate_pulse : ext_edge;
  wire [MEAS_W-1:0] target = pulse_ref ? FRAME_OVF : WORD_OVF;
  wire slow = meas_cnt_reg < target;
  wire fast = meas_cnt_reg > target;
  wire [ACC_W-1:0] inc_up = base_inc_reg + FLL_STEP;
  wire [ACC_W-1:0] inc_dn = base_inc_reg - FLL_STEP;
  wire want_out = (slow && inc_up > INC_MAX) || (fast && inc_dn < INC_MIN);
  wire timed_out = loss_cnt_reg == LW'(LOSS_CYC_P);
  wire ref_lost = !internal && (timed_out || out_lock_reg);
  wire cfg_bad = pos_src_reg == POS_PULSE && !pulse_ref;

  always_comb begin
    base_inc_next = base_inc_reg;
    if (internal) begin
      base_inc_next = ACC_W'(INC_NOM);
    end else if (ref_lost) begin
      if (!rate_hold_reg) base_inc_next = ACC_W'(INC_NOM);
    end else if (fll_evt && !want_out) begin
      if (slow) base_inc_next = inc_up;
      else if (fast) base_inc_next = inc_dn;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_inc_reg <= ACC_W'(INC_NOM);
      meas_cnt_reg <= '0;
      loss_cnt_reg <= '0;
      out_lock_reg <= 1'h0;
    end else begin
      base_inc_reg <= base_inc_next;
      if (fll_evt) meas_cnt_reg <= '0;
      else if (ovf_reg && meas_cnt_reg != '1) meas_cnt_reg <= meas_cnt_reg + 20'h1;
      if (act_evt || internal) loss_cnt_reg <= '0;
      else if (!timed_out) loss_cnt_reg <= loss_cnt_reg + LW'(1);
      if (internal) out_lock_reg <= 1'h0;
      else if (fll_evt) out_lock_reg <= want_out;
    end
  end

  // ----------------------------------------
  // Rate trim, clamp and accumulator
  // ----------------------------------------
  // Trim only bends the crystal; a tracking loop would undo it
  logic [ACC_W-1:0] out_inc_reg, acc_reg;
  logic [8:0] div_reg;
  wire signed [63:0] base_s = $signed({32'h0, base_inc_reg});
  wire signed [63:0] trim_prod = base_s * 64'(trim_reg) * CENT_K;
  wire signed [63:0] raw_inc = internal ? base_s + (trim_prod >>> CENT_SHIFT) : base_s;
  wire clamp_lo = raw_inc < INC_MIN;
  wire clamp_hi = raw_inc > INC_MAX;
  wire [ACC_W-1:0] inc_sel = clamp_lo ? ACC_W'(INC_MIN) :
    clamp_hi ? ACC_W'(INC_MAX) : raw_inc[ACC_W-1:0];
  wire [ACC_W:0] acc_sum = {1'h0, acc_reg} + {1'h0, out_inc_reg};
  wire word_tick = ovf_reg && &div_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_inc_reg <= ACC_W'(INC_NOM);
      clamp_live_reg <= 1'h0;
      acc_reg <= '0;
      ovf_reg <= 1'h0;
      div_reg <= '0;
    end else begin
      out_inc_reg <= inc_sel;
      clamp_live_reg <= clamp_lo | clamp_hi;
      acc_reg <= acc_sum[ACC_W-1:0];
      ovf_reg <= acc_sum[ACC_W];
      if (ovf_reg) div_reg <= div_reg + 9'h001;
    end
  end

  // ----------------------------------------
  // Generator timing and lock indicator
  // ----------------------------------------
  logic [SPF_W-1:0] samp_cnt_reg;
  logic gen_tick_reg, gen_en_reg, blink_reg, led_reg;
  logic [BW-1:0] blink_cnt_reg;
  wire frame_end = word_tick && samp_cnt_reg == SPF_LAST;
  wire bad = ref_lost || cfg_bad;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_cnt_reg <= '0;
      gen_tick_reg <= 1'h0;
      gen_en_reg <= 1'h0;
    end else begin
      if (frame_end) samp_cnt_reg <= '0;
      else if (word_tick) samp_cnt_reg <= samp_cnt_reg + 11'h001;
      gen_en_reg <= pos_src_reg == POS_GENERATE;
      gen_tick_reg <= frame_end && pos_src_reg == POS_GENERATE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'h0;
      led_reg <= 1'h0;
    end else begin
      if (blink_cnt_reg == BW'(BLINK_CYC_P - 1)) begin
        blink_cnt_reg <= '0;
        blink_reg <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + BW'(1);
      end
      led_reg <= bad ? blink_reg : 1'h1;
    end
  end

  // ----------------------------------------
  // Read mux and outputs
  // ----------------------------------------
  wire [DATA_W-1:0] ctrl_word = DATA_W'({rate_hold_reg, pos_src_reg, clk_ref_reg});
  wire [DATA_W-1:0] stat_word = DATA_W'({clamp_live_reg, cfg_bad, direction, clamp_stk_reg, ref_lost});
  assign rd_mux = dp_addr_reg == REG_CTRL ? ctrl_word :
    dp_addr_reg == REG_TRIM ? DATA_W'(trim_reg) :
    dp_addr_reg == REG_PPF ? DATA_W'(ppf_reg) :
    dp_addr_reg == REG_STAT ? stat_word :
    dp_addr_reg == REG_POS ? DATA_W'(frame_pos) :
    dp_addr_reg == REG_RATE ? out_inc_reg : '0;

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'h0;
  assign wide_clk = div_reg[0];
  assign aes_clk = div_reg[1];
  assign word_clk = div_reg[8];
  assign gen_enable = gen_en_reg;
  assign gen_frame_tick = gen_tick_reg;
  assign lock_led = led_reg;
  assign rate_clamped = clamp_live_reg;
  assign hold_nv_value = rate_hold_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_trim_lim;
    trim_reg <= TRIM_MAX && trim_reg >= -TRIM_MAX;
  endproperty
  a_trim_lim: assert property (p_trim_lim) else $error("trim beyond limit");

  property p_ppf_set;
    wr_ppf && ppf_ok |=> ppf_reg == $past(hwdata[PPF_W-1:0]) && ppf_reg >= PPF_MIN;
  endproperty
  a_ppf_set: assert property (p_ppf_set) else $error("ppf write not taken");

  property p_clamp;
    out_inc_reg >= INC_MIN && out_inc_reg <= INC_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("output rate outside clamp");

  property p_clamp_flag;
    clamp_lo || clamp_hi |=> clamp_live_reg ##1 clamp_stk_reg;
  endproperty
  a_clamp_flag: assert property (p_clamp_flag) else $error("clamp not flagged");

  property p_internal;
    internal |=> base_inc_reg == INC_NOM;
  endproperty
  a_internal: assert property (p_internal) else $error("internal rate not nominal");

  property p_hold;
    !internal && ref_lost && rate_hold_reg && !wr_ctrl |=> $stable(base_inc_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("held rate moved");

  property p_nominal;
    ref_lost && !rate_hold_reg |=> base_inc_reg == INC_NOM;
  endproperty
  a_nominal: assert property (p_nominal) else $error("lost reference not nominal");

  property p_gen_timed;
    gen_tick_reg |-> $past(word_tick) && gen_en_reg;
  endproperty
  a_gen_timed: assert property (p_gen_timed) else $error("generator tick off word clock");

  property p_panel;
    panel_edge && !wr_ctrl |=> clk_ref_reg == scr_clk_ref_e'($past(clk_ref_reg) + 2'h1);
  endproperty
  a_panel: assert property (p_panel) else $error("panel did not advance reference");

  property p_led;
    bad |=> lock_led == $past(blink_reg);
  endproperty
  a_led: assert property (p_led) else $error("lock indicator not blinking");
endmodule

//--- tb/scr_transport_model.sv
// Behavioural film transport driving two-phase or tach pulses
`timescale 1ns/1ps
module scr_transport_model (
  // Transport pins
  output logic phase_a_pin,
  output logic phase_b_pin
);
  initial begin
    phase_a_pin = 1'b0;
    phase_b_pin = 1'b0;
  end
  // Quarter steps of 16 ns make a 64 ns cycle; pins stand still between moves
  task automatic quad(input int n, input bit fwd);
    logic [7:0] seq;
    seq = fwd ? 8'b10_11_01_00 : 8'b01_11_10_00;
    // Half a clock off the edge so no move races the sampling edge
    #4;
    for (int i = 0; i < 4 * n; i++) begin
      #16 {phase_a_pin, phase_b_pin} = seq[7 - 2 * (i % 4) -: 2];
    end
  endtask
  // Tach: B is a direction level, A carries the rate pulses
  task automatic tach(input int n, input bit fwd);
    #4;
    phase_b_pin = fwd;
    for (int i = 0; i < n; i++) begin
      #32 phase_a_pin = 1'b1;
      #32 phase_a_pin = 1'b0;
    end
  endtask
endmodule

//--- tb/sync_clock_reference_select_bench.sv
// Self-checking bench of the sync clock reference block
`timescale 1ns/1ps
module sync_clock_reference_select_bench;
  import scr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, ext_ref_pin, panel_sel_pin, hold_nv_pin;
  logic [31:0] haddr, hwdata, hrdata, rd, r0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, phase_a_pin, phase_b_pin, word_clk, wide_clk, aes_clk;
  logic gen_enable, gen_frame_tick, lock_led, rate_clamped, hold_nv_value;
  int err_count, check_count, seed, pos, cnt, pulses_per_frame_setting, tg, v, t;
  int pv[8] = '{1, 2, 254, 255, 0, 0, 0, 0};
  int tv[5] = '{699, -699, 800, -1000, 0};
  assign hready = hreadyout;
  scr_top #(.LOSS_CYC_P(2000), .BLINK_CYC_P(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase_a_pin(phase_a_pin),
    .phase_b_pin(phase_b_pin), .ext_ref_pin(ext_ref_pin), .panel_sel_pin(panel_sel_pin),
    .hold_nv_pin(hold_nv_pin), .word_clk(word_clk), .wide_clk(wide_clk), .aes_clk(aes_clk),
    .gen_enable(gen_enable), .gen_frame_tick(gen_frame_tick), .lock_led(lock_led),
    .rate_clamped(rate_clamped), .hold_nv_value(hold_nv_value));
  scr_transport_model tm (.phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin));
  // ---------------------------------------------
  // Bus cycles and comparisons
  // ---------------------------------------------
  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      wrap_up;
    end
  endtask
  // Address phase held until hready, then data phase held until hready
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Reference position counter of the pulse inputs
  task automatic mdl(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      if (up && cnt == pulses_per_frame_setting - 1) begin
        cnt = 0;
        pos++;
      end else if (up) begin
        cnt++;
      end else if (cnt == 0) begin
        cnt = pulses_per_frame_setting - 1;
        pos--;
      end else begin
        cnt--;
      end
    end
  endtask
  task automatic blink(output int n);
    logic p;
    n = 0;
    p = lock_led;
    repeat (100) begin
      @(posedge hclk);
      if (lock_led !== p) n++;
      p = lock_led;
    end
  endtask
  task automatic ratio;
    int nw, nd, na;
    logic pw, pd, pa;
    nw = 0;
    nd = 0;
    na = 0;
    pw = word_clk;
    pd = wide_clk;
    pa = aes_clk;
    for (int k = 0; k < 8000 && nw < 2; k++) begin
      @(posedge hclk);
      if (nw == 1 && wide_clk === 1'b1 && pd === 1'b0) nd++;
      if (nw == 1 && aes_clk === 1'b1 && pa === 1'b0) na++;
      if (word_clk === 1'b1 && pw === 1'b0) nw++;
      pw = word_clk;
      pd = wide_clk;
      pa = aes_clk;
    end
    chk(nd >= 255 && nd <= 257, 1);
    chk(na >= 127 && na <= 129, 1);
  endtask
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    #700us;
    err_count++;
    wrap_up;
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, ext_ref_pin, panel_sel_pin} = 5'h0;
    hold_nv_pin = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    seed = 36;
    pos = 0;
    cnt = 0;
    pulses_per_frame_setting = 4;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    chk(gen_enable, 1);
    chk(lock_led, 1);
    chk(hold_nv_value, 1);
    rchk(REG_CTRL, 32'h10);
    rchk(REG_PPF, 32'h4);
    ratio;
    foreach (pv[i]) begin
      v = (i < 5) ? pv[i] : 2 + ($unsigned($random(seed)) % 253);
      if (v >= PPF_MIN && v <= PPF_MAX) pulses_per_frame_setting = v;
      bus(REG_PPF, 1'b1, 32'(v));
      rchk(REG_PPF, 32'(pulses_per_frame_setting));
    end
    bus(32'h18, 1'b1, 32'hA5A5);
    rchk(32'h18, 32'h0);
    foreach (tv[i]) begin
      t = tv[i] > TRIM_MAX ? TRIM_MAX : (tv[i] < -TRIM_MAX ? -TRIM_MAX : tv[i]);
      bus(REG_TRIM, 1'b1, 32'(tv[i]));
      rchk(REG_TRIM, 32'(t));
    end
    bus(REG_CTRL, 1'b1, 32'h04);
    repeat (4) @(posedge hclk);
    chk(gen_enable, 0);
    chk(hold_nv_value, 0);
    bus(REG_TRIM, 1'b1, 32'(699));
    repeat (4) @(posedge hclk);
    chk(rate_clamped, 1);
    rchk(REG_RATE, 32'(INC_MAX));
    bus(REG_TRIM, 1'b1, -32'sd699);
    repeat (4) @(posedge hclk);
    rchk(REG_RATE, 32'(INC_MIN));
    bus(REG_TRIM, 1'b1, 32'h0);
    repeat (4) @(posedge hclk);
    chk(rate_clamped, 0);
    rchk(REG_RATE, 32'(INC_NOM));
    bus(REG_STAT, 1'b0, 32'h0);
    chk(rd[1], 1);
    bus(REG_STAT, 1'b1, 32'h2);
    bus(REG_STAT, 1'b0, 32'h0);
    chk(rd[1], 0);
    bus(REG_CTRL, 1'b1, 32'h0C);
    bus(REG_STAT, 1'b0, 32'h0);
    chk(rd[3], 1);
    blink(tg);
    chk(tg >= 4, 1);
    pulses_per_frame_setting = 2;
    bus(REG_PPF, 1'b1, 32'h2);
    bus(REG_CTRL, 1'b1, 32'h0D);
    tm.quad(6, 1'b1);
    mdl(6, 1'b1);
    repeat (8) @(posedge hclk);
    rchk(REG_POS, 32'(pos));
    bus(REG_STAT, 1'b0, 32'h0);
    chk(rd[2], 1);
    tm.quad(4, 1'b0);
    mdl(4, 1'b0);
    repeat (8) @(posedge hclk);
    rchk(REG_POS, 32'(pos));
    bus(REG_STAT, 1'b0, 32'h0);
    chk(rd[2], 0);
    bus(REG_CTRL, 1'b1, 32'h05);
    tm.quad(2, 1'b0);
    mdl(2, 1'b1);
    repeat (8) @(posedge hclk);
    rchk(REG_POS, 32'(pos));
    bus(REG_CTRL, 1'b1, 32'h0E);
    tm.tach(2, 1'b0);
    mdl(2, 1'b0);
    repeat (8) @(posedge hclk);
    rchk(REG_POS, 32'(pos));
    bus(REG_CTRL, 1'b1, 32'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      panel_sel_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      panel_sel_pin <= 1'b0;
      repeat (6) @(posedge hclk);
      bus(REG_CTRL, 1'b0, 32'h0);
      chk(rd[1:0], (i + 1) % 4);
    end
    bus(REG_TRIM, 1'b1, 32'(100));
    repeat (4) @(posedge hclk);
    bus(REG_RATE, 1'b0, 32'h0);
    chk(rd !== 32'(INC_NOM), 1);
    // Word-rate edges faster than nominal pull the loop up, then vanish
    bus(REG_CTRL, 1'b1, 32'h13);
    repeat (4) begin
      @(posedge hclk);
      ext_ref_pin <= 1'b1;
      repeat (8) @(posedge hclk);
      ext_ref_pin <= 1'b0;
      repeat (800) @(posedge hclk);
    end
    bus(REG_RATE, 1'b0, 32'h0);
    r0 = rd;
    chk(r0 !== 32'(INC_NOM), 1);
    repeat (2100) @(posedge hclk);
    rchk(REG_RATE, r0);
    bus(REG_STAT, 1'b0, 32'h0);
    chk(rd[0], 1);
    bus(REG_CTRL, 1'b1, 32'h03);
    repeat (4) @(posedge hclk);
    rchk(REG_RATE, 32'(INC_NOM));
    blink(tg);
    chk(tg >= 4, 1);
    wrap_up;
  end
endmodule
